// ---- sim/etd_top_sva.sv ----
// checker on the ports of the trigger dispatch top
// assumes one pclk domain with async active low presetn
`timescale 1ns/1ns
module etd_top_sva
  import etd_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // channel control
  input wire logic [3:0] chan_out_on,
  input wire logic [1:0] track_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire cfg_wr = acc && pwrite && (paddr < 12'h014);
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_idle; !acc |-> !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("pslverr outside access");
  property p_unmap; acc && (paddr > 12'h02c || paddr[1:0] != 2'h0) |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_type; cfg_wr && !pwdata[31] && pwdata[6:4] > 3'h4 |-> pslverr; endproperty
  a_type: assert property (p_type) else $error("bad type accepted");
  property p_act; cfg_wr && !pwdata[31] && pwdata[15:12] > 4'h9 |-> pslverr; endproperty
  a_act: assert property (p_act) else $error("bad action accepted");
  property p_sens; cfg_wr && pwdata[31] && pwdata[9:8] == 2'h3 |-> pslverr; endproperty
  a_sens: assert property (p_sens) else $error("bad sensitivity accepted");
  property p_trk; track_mode != 2'h3; endproperty
  a_trk: assert property (p_trk) else $error("tracking code out of range");
  // no trigger can beat the synchroniser and filter out of reset
  property p_sync; $rose(presetn) |-> (chan_out_on == 4'h0) [*3]; endproperty
  a_sync: assert property (p_sync) else $error("output moved right after reset");
endmodule
bind etd_top etd_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .chan_out_on(chan_out_on), .track_mode(track_mode));

// ---- sim/etd_top_tb.sv ----
// self-checking bench for the trigger dispatch top
// assumes etd_top, its bound checker and the line driver model
`timescale 1ns/1ns
module etd_top_tb;
  import etd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] trig_line;
  logic [3:0] chan_out_on;
  logic [7:0] chan_mode;
  logic [1:0] track_mode;
  int mismatches = 0;
  int samples_checked = 0;
  etd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_line(trig_line), .chan_out_on(chan_out_on),
    .chan_mode(chan_mode), .track_mode(track_mode));
  etd_trig_src u_src (.pclk(pclk), .trig_line(trig_line));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk("prdata", exp, rd);
  endtask
  function automatic logic [31:0] cw(logic [2:0] ty, logic [3:0] ac, logic [3:0] tg, logic en);
    return {12'h000, tg, ac, 5'h00, ty, 3'h0, en};
  endfunction
  // a line change, then time for sync, filter and dispatch
  task automatic line_to(input int n, input logic v);
    u_src.set_line(n, v);
    repeat (600) @(posedge pclk);
  endtask
  task automatic outchk(input logic [3:0] exp);
    chk("chan_out_on", {28'h0, exp}, {28'h0, chan_out_on});
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop;
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(12'h000, 32'h0000_0100);
    rdchk(ETD_MODE_ADDR, 32'h0);
    apb(1'b1, 12'h004, 32'h8000_0000, 1'b1);
    rdchk(12'h004, 32'h0000_0100);
    rdchk(ETD_ERR_ADDR, 32'h1);
    apb(1'b1, ETD_ERR_ADDR, 32'h0, 1'b0);
    apb(1'b0, 12'h030, 32'h0, 1'b1);
    apb(1'b1, 12'h000, cw(3'h5, 4'h0, 4'h1, 1'b1), 1'b1);
    apb(1'b1, 12'h000, cw(3'h0, 4'ha, 4'h1, 1'b1), 1'b1);
    for (int n = 0; n < 5; n++)
    begin
      apb(1'b1, 12'(4*n), cw(3'(n), 4'(n+5), 4'(n+1), 1'b1), 1'b0);
      apb(1'b1, 12'(4*n), 32'h8000_0000 | 32'((n%3) << 8), 1'b0);
      rdchk(12'(4*n), cw(3'(n), (n == 4) ? 4'h1 : 4'(n+5), 4'(n+1), 1'b1)
            | 32'h2 | 32'((n%3) << 8));
    end
    apb(1'b1, 12'h000, 32'h8000_0300, 1'b1);
    apb(1'b1, 12'h00c, cw(3'h2, 4'h0, 4'hf, 1'b0), 1'b0);
    apb(1'b1, 12'h000, cw(3'h0, 4'h0, 4'hf, 1'b1), 1'b0);
    line_to(0, 1'b1);
    outchk(4'hf);
    apb(1'b1, 12'h004, cw(3'h4, 4'h0, 4'h3, 1'b1), 1'b0);
    line_to(1, 1'b1);
    outchk(4'hc);
    apb(1'b1, 12'h008, cw(3'h0, 4'h2, 4'h6, 1'b1), 1'b0);
    apb(1'b1, 12'h008, 32'h8000_0200, 1'b0);
    u_src.pulse(2, 50);
    repeat (600) @(posedge pclk);
    outchk(4'ha);
    apb(1'b1, 12'h008, 32'h8000_0000, 1'b0);
    u_src.pulse(2, 100);
    repeat (700) @(posedge pclk);
    outchk(4'ha);
    apb(1'b1, 12'h000, cw(3'h0, 4'h0, 4'hf, 1'b1), 1'b0);
    // line 0 still stands high: drop it, then a fresh rise turns every channel on
    line_to(0, 1'b0);
    line_to(0, 1'b1);
    line_to(1, 1'b0);
    outchk(4'hc);
    line_to(3, 1'b1);
    outchk(4'hc);
    apb(1'b1, 12'h000, cw(3'h1, 4'h8, 4'h3, 1'b1), 1'b0);
    line_to(0, 1'b0);
    rdchk(ETD_MODE_ADDR, 32'h0000_0100);
    chk("track_mode", 32'h1, {30'h0, track_mode});
    apb(1'b1, 12'h010, cw(3'h0, 4'h9, 4'h3, 1'b1), 1'b0);
    line_to(4, 1'b1);
    rdchk(ETD_MODE_ADDR, 32'h0000_0200);
    chk("track_mode", 32'h2, {30'h0, track_mode});
    apb(1'b1, 12'h00c, cw(3'h2, 4'h4, 4'h8, 1'b1), 1'b0);
    repeat (600) @(posedge pclk);
    rdchk(ETD_MODE_ADDR, 32'h0000_0240);
    chk("chan_mode", 32'h40, {24'h0, chan_mode});
    rdchk(ETD_OUT_ADDR, 32'h0000_000c);
    report_and_stop;
  end
endmodule

// ---- sim/etd_trig_src.sv ----
// far-side driver of the five trigger lines
// assumes pclk is the bench clock; lines move just after its edges
`timescale 1ns/1ns
module etd_trig_src
(
  // clock
  input wire logic pclk,
  // lines
  output logic [4:0] trig_line
);
  initial trig_line = 5'h00;
  task automatic set_line(input int n, input logic v);
    @(posedge pclk);
    trig_line[n] <= v;
  endtask
  // short pulses probe the noise filter
  task automatic pulse(input int n, input int cyc);
    set_line(n, 1'b1);
    repeat (cyc) @(posedge pclk);
    trig_line[n] <= 1'b0;
  endtask
endmodule

// ---- verilog/etd_line_det.sv ----
// one trigger line: synchroniser, noise filter, edge or level detection
// assumes the raw line is asynchronous to pclk
`timescale 1ns/1ns
module etd_line_det
  import etd_pkg::*;
#(
  parameter int FILT_LOW = ETD_FILT_LOW_CYC,
  parameter int FILT_MID = ETD_FILT_MID_CYC,
  parameter int FILT_HIGH = ETD_FILT_HIGH_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line and settings
  input wire logic line_raw,
  input wire etd_pkg::etd_type_t ttype,
  input wire etd_pkg::etd_sens_t sens,
  // result
  output logic fire,
  output logic level
);
  import etd_pkg::*;
  logic sync1_reg;
  logic sync2_reg;
  logic filt_reg;
  logic filt_d_reg;
  logic [ETD_FCNT_W-1:0] cnt_reg;
  logic [ETD_FCNT_W-1:0] cnt_next;
  logic [ETD_FCNT_W-1:0] win;
  wire differ = sync2_reg != filt_reg;
  wire settle = differ && (cnt_reg >= win);
  wire rise = filt_reg && !filt_d_reg;
  wire fall = !filt_reg && filt_d_reg;

  // lower sensitivity means a longer stable time before a change is accepted
  assign win = (sens == ETD_SENS_LOW) ? ETD_FCNT_W'(FILT_LOW - 1) :
               (sens == ETD_SENS_MID) ? ETD_FCNT_W'(FILT_MID - 1) :
               ETD_FCNT_W'(FILT_HIGH - 1);
  assign cnt_next = differ ? cnt_reg + 1'b1 : '0;
  assign level = filt_reg;

  // level types fire every cycle the level holds; action logic applies them idempotently, except toggle, which flips the output each cycle
  always_comb
  begin
    unique case (ttype)
      ETD_TYPE_RISE: fire = rise;
      ETD_TYPE_FALL: fire = fall;
      ETD_TYPE_HIGH: fire = filt_reg;
      ETD_TYPE_LOW: fire = !filt_reg;
      ETD_TYPE_ANY: fire = rise || fall;
      default: fire = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      filt_reg <= 1'b0;
      filt_d_reg <= 1'b0;
      cnt_reg <= '0;
    end
    else
    begin
      sync1_reg <= line_raw;
      sync2_reg <= sync1_reg;
      filt_d_reg <= filt_reg;
      cnt_reg <= settle ? '0 : cnt_next;
      if (settle)
        filt_reg <= sync2_reg;
    end
  end
endmodule

// ---- verilog/etd_pkg.sv ----
// package for the external trigger input dispatch block
// assumes a single 25 MHz apb clock domain
package etd_pkg;
  localparam int ETD_LINES = 5;
  localparam int ETD_CHANS = 4;
  localparam int ETD_CLK_MHZ = 25;
  // filter windows in microseconds per sensitivity level
  localparam int ETD_FILT_LOW_US = 20;
  localparam int ETD_FILT_MID_US = 4;
  localparam int ETD_FILT_HIGH_US = 1;
  localparam int ETD_FILT_LOW_CYC = ETD_FILT_LOW_US * ETD_CLK_MHZ;
  localparam int ETD_FILT_MID_CYC = ETD_FILT_MID_US * ETD_CLK_MHZ;
  localparam int ETD_FILT_HIGH_CYC = ETD_FILT_HIGH_US * ETD_CLK_MHZ;
  localparam int ETD_FCNT_W = 10;
  // register byte addresses; line config at base + 4*line
  localparam logic [11:0] ETD_CFG_BASE = 12'h000;
  localparam logic [11:0] ETD_STAT_ADDR = 12'h020;
  localparam logic [11:0] ETD_OUT_ADDR = 12'h024;
  localparam logic [11:0] ETD_MODE_ADDR = 12'h028;
  localparam logic [11:0] ETD_ERR_ADDR = 12'h02c;
  // line config field positions
  localparam int ETD_F_EN = 0;
  localparam int ETD_F_CFGD = 1;
  localparam int ETD_F_TYPE = 4;
  localparam int ETD_F_SENS = 8;
  localparam int ETD_F_ACT = 12;
  localparam int ETD_F_TGT = 16;
  localparam int ETD_F_SENS_WR = 31;
  typedef enum logic [2:0] {
    ETD_TYPE_RISE = 3'h0, ETD_TYPE_FALL = 3'h1, ETD_TYPE_HIGH = 3'h2,
    ETD_TYPE_LOW = 3'h3, ETD_TYPE_ANY = 3'h4
  } etd_type_t;
  typedef enum logic [1:0] {
    ETD_SENS_LOW = 2'h0, ETD_SENS_MID = 2'h1, ETD_SENS_HIGH = 2'h2
  } etd_sens_t;
  typedef enum logic [3:0] {
    ETD_ACT_ON = 4'h0, ETD_ACT_OFF = 4'h1, ETD_ACT_TOGGLE = 4'h2,
    ETD_ACT_POWER = 4'h3, ETD_ACT_CV = 4'h4, ETD_ACT_CC = 4'h5,
    ETD_ACT_CR = 4'h6, ETD_ACT_SEP = 4'h7, ETD_ACT_STACK = 4'h8,
    ETD_ACT_COMB = 4'h9
  } etd_act_t;
  // per channel mode codes
  localparam logic [1:0] ETD_MODE_SUPPLY = 2'h0;
  localparam logic [1:0] ETD_MODE_CV = 2'h1;
  localparam logic [1:0] ETD_MODE_CC = 2'h2;
  localparam logic [1:0] ETD_MODE_CR = 2'h3;
  // tracking codes
  localparam logic [1:0] ETD_TRK_SEP = 2'h0;
  localparam logic [1:0] ETD_TRK_STACK = 2'h1;
  localparam logic [1:0] ETD_TRK_COMB = 2'h2;
  typedef struct packed {
    logic en;
    logic cfgd;
    etd_type_t ttype;
    etd_sens_t sens;
    etd_act_t act;
    logic [3:0] tgt;
  } etd_cfg_t;
  localparam etd_cfg_t ETD_CFG_RST = '{1'b0, 1'b0, ETD_TYPE_RISE, ETD_SENS_MID,
                                       ETD_ACT_ON, 4'h0};
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } etd_apb_req_t;
endpackage

// ---- verilog/etd_top.sv ----
// external trigger input dispatch: five lines steer outputs of four channels
// assumes an apb master on pclk; trigger lines asynchronous
// Overview of operation
// - a fired line whose action is stacked tracking puts channel one and two in series tracking; the code needs both targeted and in supply mode.
// - a fired line whose action is combined tracking puts channel one and two in parallel tracking; the code needs both targeted and in supply mode.
// - the configured action of each line reads back on query.
// - each line holds a low, medium or high sensitivity that reads back.
// - a sensitivity write to a line not yet configured is rejected.
// - lower sensitivity applies a longer noise filter to the line.
// - each line has one enable per channel one to four, several may be set.
// - the target query returns every enabled channel together.
// - each line holds a detection type of rising, falling, high or low.
// - the any-edge type fires on both transitions.
// - choosing the any-edge type forces the action to output off.
// - settings are kept separately for lines zero to four.
// - a disabled line causes no action.
// - actions include on, off and toggle of each targeted channel.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module etd_top
  import etd_pkg::*;
#(
  parameter int LINES = ETD_LINES,
  parameter int CHANS = ETD_CHANS
)
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger lines
  input wire logic [LINES-1:0] trig_line,
  // channel control
  output logic [CHANS-1:0] chan_out_on,
  output logic [2*CHANS-1:0] chan_mode,
  output logic [1:0] track_mode
);
  import etd_pkg::*;

  etd_cfg_t cfg_reg [LINES];
  logic [CHANS-1:0] out_reg;
  logic [2*CHANS-1:0] mode_reg;
  logic [1:0] trk_reg;
  logic err_reg;
  logic [31:0] rdata_reg;
  logic [LINES-1:0] fire;
  logic [LINES-1:0] lvl;
  etd_apb_req_t req;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign chan_out_on = out_reg;
  assign chan_mode = mode_reg;
  assign track_mode = trk_reg;
  assign pready = 1'b1;

  function automatic logic [31:0] etd_pack(input etd_cfg_t c);
    logic [31:0] w;
    w = '0;
    w[ETD_F_EN] = c.en;
    w[ETD_F_CFGD] = c.cfgd;
    w[ETD_F_TYPE +: 3] = c.ttype;
    w[ETD_F_SENS +: 2] = c.sens;
    w[ETD_F_ACT +: 4] = c.act;
    w[ETD_F_TGT +: 4] = c.tgt;
    return w;
  endfunction

  // address decode
  wire setup = req.psel && !req.penable;
  wire acc = req.psel && req.penable;
  wire wr = acc && req.pwrite;
  wire [9:0] widx = req.paddr[11:2];
  wire is_cfg = widx < 10'(LINES);
  wire [2:0] lidx = widx[2:0];
  wire is_stat = req.paddr == ETD_STAT_ADDR;
  wire is_out = req.paddr == ETD_OUT_ADDR;
  wire is_mode = req.paddr == ETD_MODE_ADDR;
  wire is_err = req.paddr == ETD_ERR_ADDR;
  wire mapped = is_cfg || is_stat || is_out || is_mode || is_err;
  wire aligned = req.paddr[1:0] == 2'h0;
  wire sens_wr = req.pwdata[ETD_F_SENS_WR];
  wire [2:0] new_type = req.pwdata[ETD_F_TYPE +: 3];
  wire [1:0] new_sens = req.pwdata[ETD_F_SENS +: 2];
  wire type_ok = new_type <= 3'(ETD_TYPE_ANY);
  wire sens_ok = new_sens <= 2'(ETD_SENS_HIGH);
  wire act_ok = req.pwdata[ETD_F_ACT +: 4] <= 4'(ETD_ACT_COMB);
  wire cfg_hit = wr && aligned && is_cfg;
  // a sensitivity-only write needs the line already configured
  wire sens_rej = cfg_hit && sens_wr && !cfg_reg[lidx].cfgd;
  wire full_bad = cfg_hit && !sens_wr && !(type_ok && act_ok);
  wire bad_sens = cfg_hit && sens_wr && !sens_ok;
  wire bad = acc && (!mapped || !aligned) || sens_rej || full_bad || bad_sens;
  assign pslverr = bad;

  genvar g;
  generate
    for (g = 0; g < LINES; g++)
    begin : g_line
      etd_line_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .line_raw(trig_line[g]),
        .ttype(cfg_reg[g].ttype),
        .sens(cfg_reg[g].sens),
        .fire(fire[g]),
        .level(lvl[g])
      );
    end
  endgenerate

  // dispatch: lines apply in order, higher index last so it wins on conflict
  logic [CHANS-1:0] out_next;
  logic [2*CHANS-1:0] mode_next;
  logic [1:0] trk_next;
  always_comb
  begin
    out_next = out_reg;
    mode_next = mode_reg;
    trk_next = trk_reg;
    for (int l = 0; l < LINES; l++)
    begin
      if (fire[l] && cfg_reg[l].en)
      begin
        for (int c = 0; c < CHANS; c++)
        begin
          if (cfg_reg[l].tgt[c])
          begin
            unique case (cfg_reg[l].act)
              ETD_ACT_ON: out_next[c] = 1'b1;
              ETD_ACT_OFF: out_next[c] = 1'b0;
              ETD_ACT_TOGGLE: out_next[c] = !out_reg[c];
              ETD_ACT_POWER: mode_next[2*c +: 2] = ETD_MODE_SUPPLY;
              ETD_ACT_CV: mode_next[2*c +: 2] = ETD_MODE_CV;
              ETD_ACT_CC: mode_next[2*c +: 2] = ETD_MODE_CC;
              ETD_ACT_CR: mode_next[2*c +: 2] = ETD_MODE_CR;
              default: ;
            endcase
          end
        end
        // tracking applies only once software has met the channel one/two setup
        if ((&cfg_reg[l].tgt[1:0]) && mode_reg[1:0] == ETD_MODE_SUPPLY &&
            mode_reg[3:2] == ETD_MODE_SUPPLY)
        begin
          unique case (cfg_reg[l].act)
            ETD_ACT_SEP: trk_next = ETD_TRK_SEP;
            ETD_ACT_STACK: trk_next = ETD_TRK_STACK;
            ETD_ACT_COMB: trk_next = ETD_TRK_COMB;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int l = 0; l < LINES; l++)
        cfg_reg[l] <= ETD_CFG_RST;
      out_reg <= '0;
      mode_reg <= '0;
      trk_reg <= ETD_TRK_SEP;
      err_reg <= 1'b0;
    end
    else
    begin
      out_reg <= out_next;
      mode_reg <= mode_next;
      trk_reg <= trk_next;
      if (bad)
        err_reg <= 1'b1;
      else if (wr && is_err && aligned)
        err_reg <= 1'b0;
      if (cfg_hit && !bad)
      begin
        if (sens_wr)
          cfg_reg[lidx].sens <= etd_sens_t'(new_sens);
        else
        begin
          // each line's storage is independent
          cfg_reg[lidx].en <= req.pwdata[ETD_F_EN];
          cfg_reg[lidx].cfgd <= 1'b1;
          cfg_reg[lidx].ttype <= etd_type_t'(new_type);
          cfg_reg[lidx].tgt <= req.pwdata[ETD_F_TGT +: 4];
          if (etd_type_t'(new_type) == ETD_TYPE_ANY)
            cfg_reg[lidx].act <= ETD_ACT_OFF;
          else
            cfg_reg[lidx].act <= etd_act_t'(req.pwdata[ETD_F_ACT +: 4]);
        end
      end
    end
  end

  // read data registered at setup so it stands through the access phase
  wire [31:0] rd_mux = (is_cfg && aligned) ? etd_pack(cfg_reg[lidx]) :
                       is_stat ? {27'h0, lvl} :
                       is_out ? {28'h0, out_reg} :
                       is_mode ? {22'h0, trk_reg, mode_reg} :
                       is_err ? {31'h0, err_reg} : 32'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_reg <= '0;
    else if (setup && !req.pwrite)
      rdata_reg <= rd_mux;
  end
  assign prdata = rdata_reg;
endmodule
